// ### logic/dcb_pkg.sv
package dcb_pkg;

  // Controller core clock toward the memory modules
  localparam int unsigned LINK_FREQ_KHZ = 312500;
  localparam int unsigned LINK_PERIOD_PS = 3200;
  localparam int unsigned SYS_PERIOD_PS = 4000;

  // Power-up waits, least times in microseconds
  localparam int unsigned T_RST_HOLD_US = 200;
  localparam int unsigned T_CKE_WAIT_US = 500;
  localparam int unsigned RST_HOLD_CYC = (T_RST_HOLD_US * 1000000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam int unsigned CKE_WAIT_CYC = (T_CKE_WAIT_US * 1000000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam int unsigned CAL_CYC_DEF = 256;

  // Register byte offsets
  localparam logic [7:0] A_RESET = 8'h00;
  localparam logic [7:0] A_CTRL = 8'h04;
  localparam logic [7:0] A_CFG = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0c;
  localparam logic [7:0] A_TIM_LAT = 8'h10;
  localparam logic [7:0] A_TIM_INIT = 8'h14;
  localparam logic [7:0] A_TIM_DLL = 8'h18;
  localparam logic [7:0] A_MR0 = 8'h1c;
  localparam logic [7:0] A_MR3 = 8'h28;
  localparam logic [7:0] A_CAL = 8'h2c;
  localparam logic [7:0] A_ECC = 8'h30;

  // Field positions
  localparam int CFG_MODE = 0;
  localparam int CFG_WIDTH = 1;
  localparam int CFG_DUAL = 2;
  localparam int CFG_ECC = 3;
  localparam int CFG_COL = 4;
  localparam int CFG_ROW = 8;
  localparam int ECC_RAW = 31;

  // Reset values and fixed figures
  localparam logic RST_FORCE_RESET = 1'b1;
  localparam logic [4:0] BANK_LOG2 = 5'h03;
  localparam logic [4:0] MAX_SIZE_LOG2 = 5'h1e;
  localparam int unsigned ADDR_BITS = 16;

  // Init sequencer states
  typedef enum logic [3:0] {
    ST_IDLE, ST_RST_HOLD, ST_CKE_WAIT, ST_XPR, ST_MRS, ST_MRS_WAIT, ST_ZQ, ST_ZQ_WAIT, ST_DONE
  } dcb_init_st_t;

  // Command and address bundle toward the modules
  typedef struct packed {
    logic [1:0] cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [ADDR_BITS-1:0] addr;
    logic cke;
    logic mem_rst_n;
    logic [1:0] lane_en;
  } dcb_cmd_t;

endpackage : dcb_pkg

// ### logic/dcb_ctrl.sv
// The Wishbone interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
module dcb_ctrl #(
  parameter int unsigned RST_HOLD_CYCLES = dcb_pkg::RST_HOLD_CYC,
  parameter int unsigned CKE_WAIT_CYCLES = dcb_pkg::CKE_WAIT_CYC,
  parameter int unsigned CAL_CYCLES = dcb_pkg::CAL_CYC_DEF
) (
  // System clock and reset
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic WB_ACK_O,
  output logic [31:0] WB_DAT_O,
  // Memory link clock
  input wire logic LINK_CLK_I,
  // Memory command pins
  output logic [1:0] DDR_CS_N_O,
  output logic DDR_RAS_N_O,
  output logic DDR_CAS_N_O,
  output logic DDR_WE_N_O,
  output logic [2:0] DDR_BA_O,
  output logic [15:0] DDR_ADDR_O,
  output logic DDR_CKE_O,
  output logic DDR_RESET_N_O,
  output logic [1:0] DDR_LANE_EN_O
);

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic force_rst;
    logic init_tog;
    logic [11:0] cfg;
    logic [4:0] read_latency;
    logic [4:0] write_latency;
    logic [3:0] burst_length;
    logic [3:0] odt_write_delay;
    logic [3:0] odt_read_delay;
    logic [7:0] mode_set_delay;
    logic [15:0] init_delay;
    logic [15:0] dll_lock_delay;
    logic [3:0][15:0] mr;
    logic [7:0] cal_val;
    logic [15:0] cal_cnt;
    logic [15:0] ecc_word;
    logic ack_s1;
    logic ack_s2;
    logic done_s1;
    logic done_s2;
    logic busy_s1;
    logic busy_s2;
  } dcb_sys_t;

  typedef struct packed {
    logic force_s1;
    logic force_s2;
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;
    dcb_pkg::dcb_init_st_t st;
    logic [17:0] cnt;
    logic [1:0] mr_idx;
    logic done;
    logic busy;
    dcb_pkg::dcb_cmd_t cmd;
  } dcb_link_t;

  dcb_sys_t s_q;
  dcb_sys_t s_d;
  dcb_link_t l_q;
  dcb_link_t l_d;

  localparam int CFG_MODE = dcb_pkg::CFG_MODE;
  localparam int CFG_WIDTH = dcb_pkg::CFG_WIDTH;
  localparam int CFG_DUAL = dcb_pkg::CFG_DUAL;
  localparam int CFG_ECC = dcb_pkg::CFG_ECC;
  localparam int CFG_COL = dcb_pkg::CFG_COL;
  localparam int CFG_ROW = dcb_pkg::CFG_ROW;
  localparam int ECC_RAW = dcb_pkg::ECC_RAW;

  // Hamming plus overall parity over one data byte
  function automatic logic [4:0] ecc_enc(input logic [7:0] d);
    logic [3:0] c;
    c[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
    c[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
    c[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
    c[3] = d[4] ^ d[5] ^ d[6] ^ d[7];
    return {(^d) ^ (^c), c};
  endfunction : ecc_enc

  // Mode writes go out as MR2, MR3, MR1, MR0
  function automatic logic [1:0] mr_order(input logic [1:0] idx);
    case (idx)
      2'h0: return 2'h2;
      2'h1: return 2'h3;
      2'h2: return 2'h1;
      default: return 2'h0;
    endcase
  endfunction : mr_order

  // System domain
  logic req;
  logic [31:0] img;
  logic [31:0] wmask;
  logic [31:0] wd;
  logic [5:0] phys_log2;
  logic [4:0] size_log2;
  logic [4:0] usable_log2;
  logic [4:0] syndrome;
  logic pending;

  always_comb begin
    s_d = s_q;
    req = WB_CYC_I & WB_STB_I & ~s_q.ack;
    pending = s_q.init_tog ^ s_q.ack_s2;
    // Bytes = rows x cols x banks x lane bytes x ranks
    phys_log2 = 6'(s_q.cfg[CFG_ROW+:4]) + 6'(s_q.cfg[CFG_COL+:4]) + 6'h02 + {1'b0, dcb_pkg::BANK_LOG2}
      + 6'(s_q.cfg[CFG_WIDTH]) + 6'(s_q.cfg[CFG_DUAL]);
    size_log2 = (phys_log2 > {1'b0, dcb_pkg::MAX_SIZE_LOG2}) ? dcb_pkg::MAX_SIZE_LOG2 : phys_log2[4:0];
    usable_log2 = size_log2 - 5'(s_q.cfg[CFG_ECC]);
    syndrome = s_q.cfg[CFG_ECC] ? (s_q.ecc_word[12:8] ^ ecc_enc(s_q.ecc_word[7:0])) : 5'h00;
    case (WB_ADR_I & 8'hfc)
      dcb_pkg::A_RESET: img = {31'h0, s_q.force_rst};
      dcb_pkg::A_CTRL: img = {31'h0, pending | s_q.busy_s2};
      dcb_pkg::A_CFG: img = {20'h0, s_q.cfg};
      dcb_pkg::A_STAT: img = {11'h0, size_log2, 3'h0, usable_log2, 6'h0, pending | s_q.busy_s2, s_q.done_s2};
      dcb_pkg::A_TIM_LAT: img = {4'h0, s_q.odt_read_delay, s_q.odt_write_delay, s_q.burst_length,
        3'h0, s_q.write_latency, 3'h0, s_q.read_latency};
      dcb_pkg::A_TIM_INIT: img = {8'h0, s_q.mode_set_delay, s_q.init_delay};
      dcb_pkg::A_TIM_DLL: img = {16'h0, s_q.dll_lock_delay};
      dcb_pkg::A_MR0, dcb_pkg::A_MR0 + 8'h04, dcb_pkg::A_MR0 + 8'h08, dcb_pkg::A_MR3:
        img = {16'h0, s_q.mr[2'(WB_ADR_I[7:2] - dcb_pkg::A_MR0[7:2])]};
      dcb_pkg::A_CAL: img = {24'h0, s_q.cal_val};
      dcb_pkg::A_ECC: img = {11'h0, syndrome, s_q.ecc_word};
      default: img = 32'h0;
    endcase
    wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
    wd = (img & ~wmask) | (WB_DAT_I & wmask);
    s_d.ack = req;
    s_d.rdat = (req & ~WB_WE_I) ? img : 32'h0;
    // Synchronisers from the link domain
    s_d.ack_s1 = l_q.tog_s3;
    s_d.ack_s2 = s_q.ack_s1;
    s_d.done_s1 = l_q.done;
    s_d.done_s2 = s_q.done_s1;
    s_d.busy_s1 = l_q.busy;
    s_d.busy_s2 = s_q.busy_s1;
    // Pad calibration; running bit drops when the count expires
    if (s_q.cal_cnt != 16'h0) begin
      s_d.cal_cnt = s_q.cal_cnt - 16'h1;
      if (s_q.cal_cnt == 16'h1) begin
        s_d.cal_val[0] = 1'b0;
      end
    end
    if (req & WB_WE_I) begin
      case (WB_ADR_I & 8'hfc)
        dcb_pkg::A_RESET: s_d.force_rst = wd[0];
        dcb_pkg::A_CTRL: begin
          // A second request while a run is pending is dropped
          if (wd[0] & ~s_q.force_rst & ~pending & ~s_q.busy_s2) begin
            s_d.init_tog = ~s_q.init_tog;
          end
        end
        dcb_pkg::A_CFG: s_d.cfg = wd[11:0];
        dcb_pkg::A_TIM_LAT: begin
          s_d.read_latency = wd[4:0];
          s_d.write_latency = wd[12:8];
          s_d.burst_length = wd[19:16];
          s_d.odt_write_delay = wd[23:20];
          s_d.odt_read_delay = wd[27:24];
        end
        dcb_pkg::A_TIM_INIT: begin
          s_d.init_delay = wd[15:0];
          s_d.mode_set_delay = wd[23:16];
        end
        dcb_pkg::A_TIM_DLL: s_d.dll_lock_delay = wd[15:0];
        dcb_pkg::A_MR0, dcb_pkg::A_MR0 + 8'h04, dcb_pkg::A_MR0 + 8'h08, dcb_pkg::A_MR3:
          s_d.mr[2'(WB_ADR_I[7:2] - dcb_pkg::A_MR0[7:2])] = wd[15:0];
        dcb_pkg::A_CAL: begin
          s_d.cal_val = wd[7:0];
          s_d.cal_cnt = wd[0] ? 16'(CAL_CYCLES) : 16'h0;
        end
        dcb_pkg::A_ECC: begin
          // Raw write lets software plant a faulty check byte
          s_d.ecc_word[7:0] = wd[7:0];
          s_d.ecc_word[15:8] = (s_q.cfg[CFG_ECC] & ~wd[ECC_RAW]) ? {3'h0, ecc_enc(wd[7:0])} : wd[15:8];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      s_q <= '0;
      s_q.force_rst <= dcb_pkg::RST_FORCE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Link domain
  logic start;
  logic cnt_zero;
  dcb_pkg::dcb_cmd_t nop;

  always_comb begin
    l_d = l_q;
    l_d.force_s1 = s_q.force_rst;
    l_d.force_s2 = l_q.force_s1;
    l_d.tog_s1 = s_q.init_tog;
    l_d.tog_s2 = l_q.tog_s1;
    l_d.tog_s3 = l_q.tog_s2;
    start = l_q.tog_s2 ^ l_q.tog_s3;
    cnt_zero = (l_q.cnt == 18'h0);
    l_d.cnt = cnt_zero ? 18'h0 : l_q.cnt - 18'h1;
    nop = l_q.cmd;
    nop.cs_n = 2'b11;
    nop.ras_n = 1'b1;
    nop.cas_n = 1'b1;
    nop.we_n = 1'b1;
    nop.ba = 3'h0;
    nop.addr = '0;
    l_d.cmd = nop;
    if (l_q.force_s2) begin
      // Modules held in reset, no commands
      l_d.st = dcb_pkg::ST_IDLE;
      l_d.cmd.cke = 1'b0;
      l_d.cmd.mem_rst_n = 1'b0;
      l_d.done = 1'b0;
      l_d.busy = 1'b0;
    end else begin
      case (l_q.st)
        dcb_pkg::ST_IDLE, dcb_pkg::ST_DONE: begin
          if (start) begin
            // Config is held steady by software while a run is pending
            l_d.st = dcb_pkg::ST_RST_HOLD;
            l_d.cnt = 18'(RST_HOLD_CYCLES);
            l_d.busy = 1'b1;
            l_d.done = 1'b0;
            l_d.cmd.cke = 1'b0;
            l_d.cmd.mem_rst_n = 1'b0;
            l_d.cmd.lane_en = s_q.cfg[CFG_WIDTH] ? 2'b11 : 2'b01;
          end
        end
        dcb_pkg::ST_RST_HOLD: begin
          if (cnt_zero) begin
            l_d.cmd.mem_rst_n = 1'b1;
            l_d.st = dcb_pkg::ST_CKE_WAIT;
            l_d.cnt = 18'(CKE_WAIT_CYCLES);
          end
        end
        dcb_pkg::ST_CKE_WAIT: begin
          if (cnt_zero) begin
            l_d.cmd.cke = 1'b1;
            l_d.st = dcb_pkg::ST_XPR;
            l_d.cnt = 18'(s_q.init_delay);
          end
        end
        dcb_pkg::ST_XPR: begin
          if (cnt_zero) begin
            l_d.st = dcb_pkg::ST_MRS;
            l_d.mr_idx = 2'h0;
          end
        end
        dcb_pkg::ST_MRS: begin
          l_d.cmd.cs_n = s_q.cfg[CFG_DUAL] ? 2'b00 : 2'b10;
          l_d.cmd.ras_n = 1'b0;
          l_d.cmd.cas_n = 1'b0;
          l_d.cmd.we_n = 1'b0;
          l_d.cmd.ba = {1'b0, mr_order(l_q.mr_idx)};
          l_d.cmd.addr = s_q.mr[mr_order(l_q.mr_idx)];
          l_d.cnt = 18'(s_q.mode_set_delay);
          l_d.st = dcb_pkg::ST_MRS_WAIT;
        end
        dcb_pkg::ST_MRS_WAIT: begin
          if (cnt_zero) begin
            l_d.mr_idx = l_q.mr_idx + 2'h1;
            l_d.st = (l_q.mr_idx == 2'h3) ? dcb_pkg::ST_ZQ : dcb_pkg::ST_MRS;
          end
        end
        dcb_pkg::ST_ZQ: begin
          // Long ZQ calibration; DLL lock covered by the same wait
          l_d.cmd.cs_n = s_q.cfg[CFG_DUAL] ? 2'b00 : 2'b10;
          l_d.cmd.we_n = 1'b0;
          l_d.cmd.addr[10] = 1'b1;
          l_d.cnt = 18'(s_q.dll_lock_delay);
          l_d.st = dcb_pkg::ST_ZQ_WAIT;
        end
        dcb_pkg::ST_ZQ_WAIT: begin
          if (cnt_zero) begin
            l_d.done = 1'b1;
            l_d.busy = 1'b0;
            l_d.st = dcb_pkg::ST_DONE;
          end
        end
        default: l_d.st = dcb_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge LINK_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      l_q <= '0;
      l_q.st <= dcb_pkg::ST_IDLE;
      l_q.cmd.cs_n <= 2'b11;
      l_q.cmd.ras_n <= 1'b1;
      l_q.cmd.cas_n <= 1'b1;
      l_q.cmd.we_n <= 1'b1;
    end else begin
      l_q <= l_d;
    end
  end

  assign WB_ACK_O = s_q.ack;
  assign WB_DAT_O = s_q.rdat;
  assign DDR_CS_N_O = l_q.cmd.cs_n;
  assign DDR_RAS_N_O = l_q.cmd.ras_n;
  assign DDR_CAS_N_O = l_q.cmd.cas_n;
  assign DDR_WE_N_O = l_q.cmd.we_n;
  assign DDR_BA_O = l_q.cmd.ba;
  assign DDR_ADDR_O = l_q.cmd.addr;
  assign DDR_CKE_O = l_q.cmd.cke;
  assign DDR_RESET_N_O = l_q.cmd.mem_rst_n;
  assign DDR_LANE_EN_O = l_q.cmd.lane_en;

endmodule : dcb_ctrl

// ### verification/dcb_ctrl_asserts.sv
`timescale 1ns/100ps
module dcb_ctrl_asserts #(
  parameter int unsigned CKE_WAIT_CYCLES = 4
) (
  // Clocks and reset
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic LINK_CLK_I,
  // Wishbone
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic WB_ACK_O,
  input wire logic [31:0] WB_DAT_O,
  // Memory pins
  input wire logic [1:0] DDR_CS_N_O,
  input wire logic DDR_RAS_N_O,
  input wire logic DDR_CAS_N_O,
  input wire logic DDR_WE_N_O,
  input wire logic [2:0] DDR_BA_O,
  input wire logic [15:0] DDR_ADDR_O,
  input wire logic DDR_CKE_O,
  input wire logic DDR_RESET_N_O,
  input wire logic [1:0] DDR_LANE_EN_O
);
  // Link cycles since module reset went high
  logic [31:0] hi_cnt_q;
  always_ff @(posedge LINK_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) hi_cnt_q <= 32'h0;
    else if (!DDR_RESET_N_O) hi_cnt_q <= 32'h0;
    else hi_cnt_q <= hi_cnt_q + 32'h1;
  end
  a_ack_on_req: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("ack late");
  a_ack_one_pulse: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
  a_dat_idle_zero: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    !WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("data without ack");
  a_no_cmd_forced: assert property (@(posedge LINK_CLK_I) disable iff (!RESET_N_I)
    !DDR_RESET_N_O |-> DDR_CS_N_O == 2'b11 && !DDR_CKE_O) else $error("command in reset");
  a_cmd_one_cycle: assert property (@(posedge LINK_CLK_I) disable iff (!RESET_N_I)
    DDR_CS_N_O != 2'b11 |=> DDR_CS_N_O == 2'b11 && DDR_ADDR_O == 16'h0 && DDR_BA_O == 3'h0)
    else $error("command held");
  a_cs_row_legal: assert property (@(posedge LINK_CLK_I) disable iff (!RESET_N_I)
    DDR_CS_N_O != 2'b11 |-> DDR_CS_N_O inside {2'b00, 2'b10}) else $error("bad select");
  a_lanes_legal: assert property (@(posedge LINK_CLK_I) disable iff (!RESET_N_I)
    $rose(DDR_CKE_O) |-> DDR_LANE_EN_O inside {2'b01, 2'b11}) else $error("bad lanes");
  a_cke_wait_met: assert property (@(posedge LINK_CLK_I) disable iff (!RESET_N_I)
    $rose(DDR_CKE_O) |-> hi_cnt_q >= CKE_WAIT_CYCLES) else $error("cke early");
endmodule : dcb_ctrl_asserts

bind dcb_ctrl dcb_ctrl_asserts #(.CKE_WAIT_CYCLES(CKE_WAIT_CYCLES)) u_chk (.*);

// ### verification/dcb_mem_model.sv
`timescale 1ns/100ps
module dcb_mem_model (
  // Link clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Command pins
  input wire logic [1:0] cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [2:0] ba_i,
  input wire logic [15:0] addr_i,
  input wire logic cke_i,
  input wire logic mem_rst_n_i,
  // Observed sequence
  output logic [3:0] mrs_cnt_o,
  output logic [3:0] zq_cnt_o,
  output logic [3:0] bad_cnt_o,
  output logic [15:0] mr_seen_o [4]
);
  // Mode writes must arrive as MR2, MR3, MR1, MR0
  localparam logic [2:0] MRS_BA [4] = '{3'h2, 3'h3, 3'h1, 3'h0};
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mrs_cnt_o <= 4'h0;
      zq_cnt_o <= 4'h0;
      bad_cnt_o <= 4'h0;
    end else if (cs_n_i != 2'b11) begin
      if (!cke_i || !mem_rst_n_i) bad_cnt_o <= bad_cnt_o + 4'h1;
      else if (!ras_n_i && !cas_n_i && !we_n_i && mrs_cnt_o < 4'h4 && ba_i == MRS_BA[mrs_cnt_o[1:0]]) begin
        mr_seen_o[ba_i[1:0]] <= addr_i;
        mrs_cnt_o <= mrs_cnt_o + 4'h1;
      end else if (ras_n_i && cas_n_i && !we_n_i && addr_i[10] && mrs_cnt_o == 4'h4) zq_cnt_o <= zq_cnt_o + 4'h1;
      else bad_cnt_o <= bad_cnt_o + 4'h1;
    end
  end
endmodule : dcb_mem_model

// ### verification/tb.sv
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0, lclk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack, ras_n, cas_n, we_n, cke, mrst_n;
  logic [1:0] cs_n, lane_en;
  logic [2:0] ba;
  logic [15:0] addr;
  logic [3:0] mrs_cnt, zq_cnt, bad_cnt;
  logic [15:0] mr_seen [4];
  logic [15:0] mr_exp [4];
  int error_cnt = 0, checked = 0;
  initial forever #2 clk = ~clk;
  // Link clock offset so edges never line up
  initial begin
    #1.3;
    forever #24 lclk = ~lclk;
  end
  dcb_ctrl #(.RST_HOLD_CYCLES(4), .CKE_WAIT_CYCLES(4), .CAL_CYCLES(4)) dut_u (
    .REF_CLK_I(clk), .RESET_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_ACK_O(ack), .WB_DAT_O(rdat),
    .LINK_CLK_I(lclk), .DDR_CS_N_O(cs_n), .DDR_RAS_N_O(ras_n), .DDR_CAS_N_O(cas_n),
    .DDR_WE_N_O(we_n), .DDR_BA_O(ba), .DDR_ADDR_O(addr), .DDR_CKE_O(cke),
    .DDR_RESET_N_O(mrst_n), .DDR_LANE_EN_O(lane_en));
  dcb_mem_model mem_u (.clk_i(lclk), .rst_n_i(rst_n), .cs_n_i(cs_n), .ras_n_i(ras_n),
    .cas_n_i(cas_n), .we_n_i(we_n), .ba_i(ba), .addr_i(addr), .cke_i(cke), .mem_rst_n_i(mrst_n),
    .mrs_cnt_o(mrs_cnt), .zq_cnt_o(zq_cnt), .bad_cnt_o(bad_cnt), .mr_seen_o(mr_seen));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Classic single cycle, held until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    @(posedge clk);
    while (ack !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) error_cnt++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  // Module time to cycles, rounded up
  function automatic logic [15:0] cyc_of(input int ps);
    return 16'((ps + 3199) / 3200);
  endfunction : cyc_of
  task t_forced();
    wb(1'b0, dcb_pkg::A_RESET, 32'h0);
    chk(q, 32'h1);
    wb(1'b1, dcb_pkg::A_CTRL, 32'h1);
    repeat (40) @(posedge clk);
    wb(1'b0, dcb_pkg::A_CTRL, 32'h0);
    chk(q, 32'h0);
    chk({28'h0, mrs_cnt | {3'h0, mrst_n}}, 32'h0);
    wb(1'b0, 8'h3c, 32'h0);
    chk(q, 32'h0);
  endtask : t_forced
  task t_timing();
    mr_exp = '{16'(((11 - 4) << 4) | ((12 - 4) << 9)), 16'h0040, 16'((8 - 5) << 3), 16'h0000};
    wb(1'b1, dcb_pkg::A_RESET, 32'h0);
    wb(1'b1, dcb_pkg::A_TIM_LAT, 32'h0224080b);
    wb(1'b1, dcb_pkg::A_TIM_INIT, {8'h0, 8'd12 > cyc_of(15000) ? 8'd12 : 8'(cyc_of(15000)), cyc_of(170000)});
    wb(1'b1, dcb_pkg::A_TIM_DLL, 32'd512);
    for (int i = 0; i < 4; i++) wb(1'b1, dcb_pkg::A_MR0 + 8'(4 * i), {16'h0, mr_exp[i]});
    wb(1'b0, dcb_pkg::A_MR0, 32'h0);
    chk(q, 32'h1070);
    wb(1'b0, dcb_pkg::A_TIM_LAT, 32'h0);
    chk(q, 32'h0224080b);
  endtask : t_timing
  task t_calib();
    int n;
    n = 0;
    wb(1'b1, dcb_pkg::A_CAL, 32'hef);
    wb(1'b0, dcb_pkg::A_CAL, 32'h0);
    chk(q, 32'hef);
    while (q[0] !== 1'b0 && n < 20) begin
      wb(1'b0, dcb_pkg::A_CAL, 32'h0);
      n++;
    end
    chk(q, 32'hee);
  endtask : t_calib
  task t_init();
    int n;
    n = 0;
    wb(1'b1, dcb_pkg::A_CFG, 32'he93);
    wb(1'b1, dcb_pkg::A_CTRL, 32'h1);
    wb(1'b0, dcb_pkg::A_STAT, 32'h0);
    while (q[0] !== 1'b1 && n < 5000) begin
      wb(1'b0, dcb_pkg::A_STAT, 32'h0);
      n++;
    end
    chk(q & 32'h1f1f03, 32'h1d1d01);
    chk({20'h0, mrs_cnt, zq_cnt, bad_cnt}, 32'h410);
    for (int i = 0; i < 4; i++) chk({16'h0, mr_seen[i]}, {16'h0, mr_exp[i]});
    chk({30'h0, lane_en}, 32'h3);
  endtask : t_init
  task t_ecc();
    wb(1'b1, dcb_pkg::A_CFG, 32'he9b);
    wb(1'b0, dcb_pkg::A_STAT, 32'h0);
    chk(q & 32'h1f1f00, 32'h1d1c00);
    wb(1'b1, dcb_pkg::A_ECC, 32'ha5);
    wb(1'b0, dcb_pkg::A_ECC, 32'h0);
    chk(q & 32'h1fffff, 32'h03a5);
    // Raw write plants a zero check byte, so the syndrome must show the damage
    wb(1'b1, dcb_pkg::A_ECC, 32'h800000a5);
    wb(1'b0, dcb_pkg::A_ECC, 32'h0);
    chk(q & 32'h1fffff, 32'h0300a5);
    wb(1'b1, dcb_pkg::A_CFG, 32'hff7);
    wb(1'b0, dcb_pkg::A_STAT, 32'h0);
    chk(q & 32'h1f1f00, 32'h1e1e00);
  endtask : t_ecc
  task tally_and_finish();
    if (error_cnt == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_forced();
    t_timing();
    t_calib();
    t_init();
    t_ecc();
    tally_and_finish();
  end
  // Bring-up needs about 31 us; a hang stops at 200 us, over six times that
  initial begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end
endmodule : tb
